// >>> pkg/sar_adc_regs.svh
// register field positions and timing counts for the converter control block
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH
`define MUX_ADDR_MSB      4
`define SIGN_SEL_BIT      5
`define RES_SEL_BIT       6
`define JUST_SEL_BIT      7
`define CTRL_RESET        8'h00
`define ACQ_HALF_CYCLES   4'h3
`define CONV_8_CYCLES     4'h8
`define CONV_8S_CYCLES    4'h9
`define CONV_10_CYCLES    4'ha
`define CONV_10S_CYCLES   4'hb
`endif

// >>> pkg/sar_adc_pkg.sv
// types shared by the converter control modules
package sar_adc_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACQ  = 2'b01,
		ST_CONV = 2'b11
	} conv_state_t;
	typedef enum logic [1:0] {
		MUX_DIFF   = 2'b00,
		MUX_SINGLE = 2'b01,
		MUX_PSEUDO = 2'b11,
		MUX_BAD    = 2'b10
	} mux_mode_t;
endpackage

// >>> pkg/result_if.sv
// carrier between sequencer and result formatter
`timescale 1ns/1ps
interface result_if;
	logic        load;
	logic [10:0] code;
	logic        sign_sel;
	logic        res_sel;
	logic        just_sel;
	logic [7:0]  byte1;
	logic [7:0]  byte2;
	modport seq (output load, code, sign_sel, res_sel, just_sel,
		input byte1, byte2);
	modport fmt (input load, code, sign_sel, res_sel, just_sel,
		output byte1, byte2);
endinterface

// >>> rtl/result_format.sv
// result formatter: packs the raw code into two output bytes
`timescale 1ns/1ps
module result_format (
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic clk_en_i,
	result_if.fmt     rif
);
	import sar_adc_pkg::*;
	// code is sign at bit 10, magnitude/two's value in 9:0
	wire       sgn = rif.code[10] & ~rif.sign_sel;
	wire [9:0] v10 = rif.code[9:0];
	wire [7:0] v8  = rif.code[9:2];
	wire [15:0] word_r;
	wire [15:0] word_l;
	// right justified: pad upper positions with sign or zero
	assign word_r = rif.res_sel ? {{8{sgn}}, v8}
		: {{6{sgn}}, v10};
	// left justified: msb at bit 7 of byte one, zeros trail
	assign word_l = rif.res_sel
		? (rif.sign_sel ? {v8, 8'h00} : {sgn, v8, 7'h00})
		: (rif.sign_sel ? {v10, 6'h00} : {sgn, v10, 5'h00});
	wire [15:0] word = rif.just_sel ? word_l : word_r;
	// formatted bytes held until the next result commits
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rif.byte1 <= 8'h00;
			rif.byte2 <= 8'h00;
		end else if (clk_en_i && rif.load) begin
			rif.byte1 <= word[15:8];
			rif.byte2 <= word[7:0];
		end
	end
endmodule

// >>> rtl/sar_adc_host_interface.sv
// converter control logic with parallel host port
`timescale 1ns/1ps
`include "sar_adc_regs.svh"
// Overview of operation
// - cs and write low latch control byte
// - bits 4:0 mux, 5 sign, 6 res, 7 just
// - signed fills leading bits with sign
// - resolution select gives 8 or 10 bits
// - justify select, high byte always first
// - write strobe rise sets start flag
// - acquisition three half-rate periods
// - conversion 8 to 11 half-rate cycles
// - half-rate clock keeps fixed phase
// - done asserts on half-rate edge
// - done low when result ready
// - first read presents byte one
// - read strobe fall clears done
// - second read presents byte two
// - new start accepted before second read
// - cs write read low restarts unchanged
// - byte packing per justification
// - eight-channel mux decode
// - four-channel mux decode
// - first of write or cs rise starts
// - drive data only while cs read low
// - unsigned negative input gives zeros
module sar_adc_host_interface (
	input  wire logic                     ref_clk_i,
	input  wire logic                     reset_i,
	input  wire logic                     clk_en_i,
	input  wire logic                     cs_n_i,
	input  wire logic                     wr_n_i,
	input  wire logic                     rd_n_i,
	input  wire logic [7:0]               data_bus_bits_i,
	output logic      [7:0]               data_bus_bits_o,
	output logic                          data_bus_bits_oe_o,
	output logic                          done_n_o,
	input  wire logic                     comparator_i,
	input  wire logic                     input_negative_i,
	output logic                          acquire_o,
	output logic                          hold_o,
	output logic      [9:0]               dac_code_o,
	output logic                          eight_channel_i_unused_o,
	output logic      [7:0]               pos_select_o,
	output logic      [8:0]               neg_select_o,
	output sar_adc_pkg::mux_mode_t        mux_mode_o
);
	import sar_adc_pkg::*;
	result_if rif ();
	logic [7:0]  ctrl;
	logic        wr_act_q;
	logic        start_flag;
	logic        half_phase;
	logic        rd_q;
	logic        byte_ptr;
	conv_state_t state;
	logic [3:0]  cnt;
	logic [10:0] sar;
	logic [10:0] trial;
	// host strobes decoded
	wire wr_act  = ~cs_n_i & ~wr_n_i;
	wire rd_act  = ~cs_n_i & ~rd_n_i;
	wire restart = wr_act & ~rd_n_i;
	wire wr_end  = wr_act_q & ~wr_act;
	wire rd_fall = rd_act & ~rd_q;
	wire half_edge = half_phase;
	wire [4:0] mux_address = ctrl[`MUX_ADDR_MSB:0];
	wire sign_sel = ctrl[`SIGN_SEL_BIT];
	wire res_sel  = ctrl[`RES_SEL_BIT];
	wire just_sel = ctrl[`JUST_SEL_BIT];
	// conversion length from mode bits
	wire [3:0] conv_len = res_sel
		? (sign_sel ? `CONV_8_CYCLES : `CONV_8S_CYCLES)
		: (sign_sel ? `CONV_10_CYCLES : `CONV_10S_CYCLES);
	wire [3:0] bit_idx = 4'(conv_len - cnt - 4'h1);
	// half-rate edge that ends a conversion
	wire conv_end_edge = half_edge && state == ST_CONV
		&& cnt == 4'(conv_len - 4'h1);
	// flag may only be consumed where the sequencer looks at it
	wire start_take = half_edge && (state == ST_IDLE || conv_end_edge);
	assign eight_channel_i_unused_o = 1'b0;
	// control latch, writes ignored during combined restart
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			ctrl <= `CTRL_RESET;
		else if (clk_en_i && wr_act && rd_n_i)
			ctrl <= data_bus_bits_i;
	end
	// strobe history
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			wr_act_q <= 1'b0;
			rd_q     <= 1'b0;
		end else if (clk_en_i) begin
			wr_act_q <= wr_act;
			rd_q     <= rd_act;
		end
	end
	// free-running half-rate phase
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			half_phase <= 1'b0;
		else if (clk_en_i)
			half_phase <= ~half_phase;
	end
	// start flag: set wins; a request during conversion waits for its end
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			start_flag <= 1'b0;
		else if (clk_en_i) begin
			if (wr_end || (restart && !wr_act_q))
				start_flag <= 1'b1;
			else if (start_take)
				start_flag <= 1'b0;
		end
	end
	// sequencer
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			cnt   <= 4'h0;
		end else if (clk_en_i && half_edge) begin
			unique case (state)
			ST_IDLE: if (start_flag) begin
				state <= ST_ACQ;
				cnt   <= 4'h0;
			end
			ST_ACQ: if (cnt == 4'(`ACQ_HALF_CYCLES - 4'h1)) begin
				state <= ST_CONV;
				cnt   <= 4'h0;
			end else
				cnt <= cnt + 4'h1;
			ST_CONV: if (cnt == 4'(conv_len - 4'h1)) begin
				state <= start_flag ? ST_ACQ : ST_IDLE;
				cnt   <= 4'h0;
			end else
				cnt <= cnt + 4'h1;
			default: state <= ST_IDLE;
			endcase
		end
	end
	// successive approximation register
	assign trial = sar | (11'h001 << bit_idx);
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			sar <= 11'h000;
		else if (clk_en_i && half_edge) begin
			if (state == ST_ACQ)
				sar <= 11'h000;
			else if (state == ST_CONV)
				sar <= comparator_i ? trial : sar;
		end
	end
	wire conv_last = clk_en_i && half_edge && state == ST_CONV
		&& cnt == 4'(conv_len - 4'h1);
	wire [10:0] final_code = comparator_i ? trial : sar;
	// align raw code: top bit sign for signed modes, 10 value bits
	wire [10:0] aligned = res_sel
		? (sign_sel ? {1'b0, final_code[7:0], 2'b00}
			: {final_code[8], final_code[7:0], 2'b00})
		: (sign_sel ? {1'b0, final_code[9:0]} : final_code);
	wire clamp = sign_sel & input_negative_i;
	assign rif.load     = conv_last;
	assign rif.code     = clamp ? 11'h000 : aligned;
	assign rif.sign_sel = sign_sel;
	assign rif.res_sel  = res_sel;
	assign rif.just_sel = just_sel;
	result_format u_fmt (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.clk_en_i  (clk_en_i),
		.rif       (rif)
	);
	// done flag: set on conversion end, cleared by read fall
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			done_n_o <= 1'b1;
		else if (clk_en_i) begin
			if (conv_last)
				done_n_o <= 1'b0;
			else if (rd_fall)
				done_n_o <= 1'b1;
		end
	end
	// byte pointer
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			byte_ptr <= 1'b0;
		else if (clk_en_i) begin
			if (conv_last)
				byte_ptr <= 1'b0;
			else if (rd_q && !rd_act)
				byte_ptr <= ~byte_ptr;
		end
	end
	// output bus
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			data_bus_bits_o <= 8'h00;
		else if (clk_en_i)
			data_bus_bits_o <= byte_ptr ? rif.byte2 : rif.byte1;
	end
	assign data_bus_bits_oe_o = rd_act & wr_n_i;
	assign acquire_o  = state == ST_ACQ;
	assign hold_o     = state == ST_CONV;
	assign dac_code_o = trial[9:0];
	// mux decode, eight-channel form with four-channel subset
	wire [1:0] mode_bits = mux_address[4:3];
	always_comb begin
		pos_select_o = 8'h00;
		neg_select_o = 9'h000;
		mux_mode_o   = MUX_DIFF;
		if (!mode_bits[0]) begin
			pos_select_o[{mux_address[2:1], mux_address[0]}] = 1'b1;
			neg_select_o[{mux_address[2:1], ~mux_address[0]}] = 1'b1;
		end else if (!mode_bits[1]) begin
			mux_mode_o = MUX_SINGLE;
			pos_select_o[mux_address[2:0]] = 1'b1;
			neg_select_o[8] = 1'b1;
		end else begin
			mux_mode_o = MUX_PSEUDO;
			pos_select_o[mux_address[2:0]] = 1'b1;
			neg_select_o[7] = 1'b1;
		end
	end
	// done goes low only on a half-rate edge
	a_done_phase: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		$fell(done_n_o) |-> $past(half_phase))
		else $error("done asserted off half-rate edge");
	// read fall releases done
	a_read_clears: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && rd_fall && !conv_last |=> done_n_o)
		else $error("read fall did not clear done");
	// data lines driven only inside read access
	a_bus_drive: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		data_bus_bits_oe_o |-> !cs_n_i && !rd_n_i)
		else $error("bus driven outside read");
	// result commit resets pointer
	a_ptr_reset: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		conv_last |=> !byte_ptr)
		else $error("pointer not reset on result");
	// write end raises start request
	a_start_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && wr_end |=> start_flag || state == ST_ACQ)
		else $error("write end lost start");
	// acquisition spans three half-rate periods
	sequence acq_run;
		state == ST_ACQ [*6];
	endsequence
	a_acq_len: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i [*7] ##0 $rose(acquire_o) |-> acq_run ##1 hold_o)
		else $error("acquisition length wrong");
	// latch captures byte on plain write
	a_ctrl_load: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && wr_act && rd_n_i |=> ctrl == $past(data_bus_bits_i))
		else $error("control byte not latched");
	// a start queued during conversion is kept until the conversion ends
	a_start_queue: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && start_flag && state == ST_CONV && !conv_end_edge
		|=> start_flag)
		else $error("queued start lost during conversion");
	// combined restart keeps configuration
	a_restart_keep: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		restart |=> $stable(ctrl))
		else $error("restart altered configuration");
endmodule

// >>> bench/analog_front.sv
// partner model: comparator of the analog front end
`timescale 1ns/1ps
module analog_front (
	input  wire logic [9:0] dac_code_i,
	input  wire logic [9:0] level_i,
	output logic            keep_o
);
	// a trial code at or below the held level keeps its bit
	assign keep_o = (dac_code_i <= level_i);
endmodule

// >>> bench/tb_sar_adc_host_interface.sv
// testbench: host bus writes, conversions and two-byte reads
`timescale 1ns/1ps
module tb_sar_adc_host_interface;
	import sar_adc_pkg::*;
	logic            ref_clk_i = 1'b0;
	logic            reset_i   = 1'b1;
	logic            cs_n      = 1'b1;
	logic            wr_n      = 1'b1;
	logic            rd_n      = 1'b1;
	logic            neg       = 1'b0;
	logic      [7:0] din       = 8'h00;
	logic      [9:0] level     = 10'h3ff;
	logic      [7:0] dout;
	logic            oe;
	logic            done_n;
	logic            keep;
	logic            acquire_o;
	logic            hold_o;
	logic      [9:0] dac_code;
	logic      [7:0] pos_select_o;
	logic      [8:0] neg_select_o;
	mux_mode_t       mux_mode_o;
	int              err_total  = 0;
	int              n_compared = 0;
	int              cycles     = 0;
	logic      [4:0] mx [3] = '{5'h03, 5'h0d, 5'h1a};
	logic      [1:0] mm [3] = '{2'b00, 2'b01, 2'b11};
	logic      [7:0] ps [3] = '{8'h08, 8'h20, 8'h04};
	logic      [8:0] ns [3] = '{9'h004, 9'h100, 9'h080};
	logic      [7:0] e1 [8] = '{8'hff, 8'h03, 8'hff, 8'h00,
		8'hff, 8'hff, 8'hff, 8'hff};
	logic      [7:0] e2 [8] = '{8'hff, 8'hff, 8'hff, 8'hff,
		8'he0, 8'hc0, 8'h80, 8'h00};

	// clock, 25 ns period
	always #12.5 ref_clk_i = ~ref_clk_i;

	sar_adc_host_interface i_sar_adc_host_interface (
		.ref_clk_i               (ref_clk_i),
		.reset_i                 (reset_i),
		.clk_en_i                (1'b1),
		.cs_n_i                  (cs_n),
		.wr_n_i                  (wr_n),
		.rd_n_i                  (rd_n),
		.data_bus_bits_i         (din),
		.data_bus_bits_o         (dout),
		.data_bus_bits_oe_o      (oe),
		.done_n_o                (done_n),
		.comparator_i            (keep),
		.input_negative_i        (neg),
		.acquire_o               (acquire_o),
		.hold_o                  (hold_o),
		.dac_code_o              (dac_code),
		.eight_channel_i_unused_o(),
		.pos_select_o            (pos_select_o),
		.neg_select_o            (neg_select_o),
		.mux_mode_o              (mux_mode_o)
	);

	analog_front i_analog_front (
		.dac_code_i(dac_code),
		.level_i   (level),
		.keep_o    (keep)
	);

	// verdict and end of run
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// control write; restart also holds the read strobe low
	task automatic write_ctrl(logic [7:0] d, bit restart);
		@(negedge ref_clk_i);
		cs_n = 1'b0;
		wr_n = 1'b0;
		rd_n = !restart;
		din = d;
		@(negedge ref_clk_i);
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
	endtask

	task automatic read_byte(logic [7:0] exp, bit first);
		@(negedge ref_clk_i);
		cs_n = 1'b0;
		rd_n = 1'b0;
		@(negedge ref_clk_i);
		check("drive enable", 1, oe);
		check("result byte", exp, dout);
		if (first)
			check("done cleared", 1, done_n);
		cs_n = 1'b1;
		rd_n = 1'b1;
		@(negedge ref_clk_i);
		check("bus released", 0, oe);
	endtask

	// acquisition and hold lengths, then the done flag
	task automatic conv(int n);
		int a;
		int h;
		int w;
		for (w = 0; acquire_o !== 1'b1 && w < 40; w++)
			@(negedge ref_clk_i);
		for (a = 0; acquire_o === 1'b1 && a < 40; a++)
			@(negedge ref_clk_i);
		for (h = 0; hold_o === 1'b1 && h < 40; h++)
			@(negedge ref_clk_i);
		for (w = 0; done_n !== 1'b0 && w < 8; w++)
			@(negedge ref_clk_i);
		check("acquire cycles", 6, a);
		check("hold cycles", n, h);
		check("done flag", 0, done_n);
	endtask

	task automatic run(logic [7:0] c, logic [7:0] b1, logic [7:0] b2, int n);
		write_ctrl(c, 0);
		conv(n);
		read_byte(b1, 1);
		read_byte(b2, 0);
	endtask

	// hang guard
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			results();
		end
	end

	initial begin
		repeat (20) @(negedge ref_clk_i);
		reset_i = 1'b0;
		check("done idle", 1, done_n);
		check("bus idle", 0, oe);
		// channel decode in all three modes
		for (int i = 0; i < 3; i++) begin
			write_ctrl({3'b111, mx[i]}, 0);
			check("mux mode", mm[i], mux_mode_o);
			check("plus select", ps[i], pos_select_o);
			check("minus select", ns[i], neg_select_o);
			conv(16);
		end
		// every sign, resolution and justification at full scale
		for (int m = 0; m < 8; m++)
			run({m[2:0], 5'h00}, e1[m], e2[m], 16 + (m[1] ? 0 : 4) +
				(m[0] ? 0 : 2));
		level = 10'h2c5;
		run(8'h20, 8'h02, 8'hc5, 20);
		run(8'ha0, 8'hb1, 8'h40, 20);
		neg = 1'b1;
		level = 10'h3ff;
		run(8'h20, 8'h00, 8'h00, 20);
		neg = 1'b0;
		level = 10'h2c5;
		// restart keeps the stored format
		write_ctrl(8'hff, 1);
		conv(20);
		read_byte(8'h02, 1);
		read_byte(8'hc5, 0);
		// new start before the second read
		write_ctrl(8'ha0, 0);
		conv(20);
		read_byte(8'hb1, 1);
		write_ctrl(8'h20, 0);
		conv(20);
		read_byte(8'h02, 1);
		read_byte(8'hc5, 0);
		// start request written while a conversion is running
		write_ctrl(8'h20, 0);
		@(posedge hold_o);
		write_ctrl(8'h20, 0);
		conv(20);
		read_byte(8'h02, 1);
		read_byte(8'hc5, 0);
		results();
	end
endmodule
